// file: tprc_pkg.sv
// Constants, field layouts and carrier types for the Type-C port route configuration block.
// Assumes a single 200 MHz clock and a host command port decoded upstream of this block.
// Operation
// R1 - Requested-connection word is 32 bits; 1 enables a function, 0 disables it.
// R2 - Bit 2 keep-alive charging, bits 4/5 high-speed A/B, bit 6 VBUS.
// R3 - Bits 7/8 superspeed lanes, 11 auto connect, 12/13/14 CC1, CC2, SBU.
// R4 - Bits 15 to 18 request CC, superspeed, SBU and high-speed flips.
// R5 - Bits 19/20 enable CC injection; 0, 1, 3, 9, 10, 21-31 reserved.
// R6 - Separate 32-bit state word; bits 0-7 report actual line enables.
// R7 - State bits 8:9 and 10:11 orientations; bits 14-16 active flips.
// R8 - State bits 19:18 card status, 22:20 error flag, 23 connection established.
// R9 - State bits 26/27 injection, 28/29 pulse detect, 30/31 CC logic level.
// R10 - Lane-direction setting accepts indices 0 to 7 only.
// R11 - Lane-direction setting decides direction of each superspeed lane and SBU.
// R12 - Exactly one mux port, chosen by channel 0 to 3, joins the common port.
// R13 - Routing style 0 is whole-port routing, 1 is split routing.
// R14 - Whole-port routing sends every enabled group to the selected channel.
// R15 - Route word assignments act only while split routing is enabled.
// R16 - Route fields: SBU1 0:1, SBU2 2:3, CC1 4:5, CC2 8:9; 6:7, 10:11 reserved.
// R17 - Route fields: HS A 12:13, HS B 14:15, SS1 16:17, SS2 18:19; 24:31 reserved.
// R18 - Route bits 20 to 23 connect VBUS to channels 0 to 3 independently.
// R19 - Two conditioners: index 0 high-speed, index 1 superspeed, separate rx and tx.
// R20 - Receiver side selector: 0 both sides, 1 mux only, 2 common only.
// R21 - High-speed conditioner keeps one shared receiver and one transmitter setting.
// R22 - Reserved bits of the three words read as zero and ignore writes.
// R23 - Cable flip 0 is normal; 1 swaps CC, VCONN, SBU and data lines.
package tprc_pkg;
    // Requested-connection word bit positions
    localparam int REQ_KEEP_ALIVE = 2;
    localparam int REQ_HS_A = 4;
    localparam int REQ_HS_B = 5;
    localparam int REQ_VBUS = 6;
    localparam int REQ_SS1 = 7;
    localparam int REQ_SS2 = 8;
    localparam int REQ_AUTO_CONN = 11;
    localparam int REQ_CC1 = 12;
    localparam int REQ_CC2 = 13;
    localparam int REQ_SBU = 14;
    localparam int REQ_FLIP_LSB = 15;
    localparam int REQ_INJ_CC1 = 19;
    localparam int REQ_INJ_CC2 = 20;
    localparam logic [31:0] REQ_WRITE_MASK = 32'h001FF9F4;
    localparam logic [31:0] REQ_RESET = 32'h00000000;
    // Actual-state word bit positions
    localparam int ST_COM_ORIENT = 8;
    localparam int ST_MUX_ORIENT = 10;
    localparam int ST_FLIP_LSB = 14;
    localparam int ST_CARD = 18;
    localparam int ST_ERR = 20;
    localparam int ST_CONN = 23;
    localparam int ST_INJ = 26;
    localparam int ST_PULSE = 28;
    localparam int ST_LEVEL = 30;
    // Route word layout, group order SBU1 SBU2 CC1 CC2 HSA HSB SS1 SS2
    localparam int NUM_GROUPS = 8;
    localparam int ROUTE_LSB [NUM_GROUPS] = '{0, 2, 4, 8, 12, 14, 16, 18};
    localparam int ROUTE_VBUS_LSB = 20;
    localparam logic [31:0] ROUTE_WRITE_MASK = 32'h00FFF33F;
    localparam logic [31:0] ROUTE_RESET = 32'h00000000;
    // Command option codes of the control port
    localparam logic [3:0] OPT_REQ_WORD = 4'h0;
    localparam logic [3:0] OPT_STATE_WORD = 4'h1;
    localparam logic [3:0] OPT_ROUTE_WORD = 4'h2;
    localparam logic [3:0] OPT_LANE_DIR = 4'h3;
    localparam logic [3:0] OPT_CHANNEL = 4'h4;
    localparam logic [3:0] OPT_STYLE = 4'h5;
    localparam logic [3:0] OPT_FLIP = 4'h6;
    localparam logic [3:0] OPT_EQ_TX = 4'h7;
    localparam logic [3:0] OPT_EQ_RX = 4'h8;
    // Setting limits and reset values
    localparam logic [31:0] LANE_DIR_MAX = 32'h00000007;
    localparam logic [31:0] CHANNEL_MAX = 32'h00000003;
    localparam logic [31:0] STYLE_MAX = 32'h00000001;
    localparam logic [31:0] HS_TX_MAX = 32'h00000003;
    localparam logic [31:0] HS_RX_MAX = 32'h00000002;
    localparam logic [31:0] SS_TX_MAX = 32'h00000008;
    localparam logic [31:0] SS_RX_MAX = 32'h0000000F;
    localparam logic [1:0] RX_SIDE_BOTH = 2'h0;
    localparam logic [1:0] RX_SIDE_MUX = 2'h1;
    localparam logic [1:0] RX_SIDE_COM = 2'h2;
    localparam logic [2:0] LANE_DIR_RESET = 3'h0;
    localparam logic [1:0] CHANNEL_RESET = 2'h0;
    localparam logic [3:0] EQ_RESET = 4'h0;
    // Direction per lane-direction index: {SBU, SS lane 2, SS lane 1}, 1 = common to mux
    localparam logic [2:0] LANE_DIR_TABLE [8] = '{3'h0, 3'h1, 3'h7, 3'h0, 3'h5, 3'h2, 3'h6, 3'h1};

    typedef struct packed {
        logic [1:0] com_orient;
        logic [1:0] mux_orient;
        logic [1:0] card;
        logic [2:0] err;
        logic conn;
        logic [1:0] pulse;
        logic [1:0] level;
    } tprc_pins_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [3:0] opt;
        logic inst;
        logic [1:0] chan;
        logic [31:0] data;
    } tprc_cmd_t;
endpackage : tprc_pkg

// file: tprc_sync.sv
// Two-stage synchroniser for a bundle of asynchronous level inputs.
// Assumes the bits are independent levels; no bus coherence is given.
`timescale 1ns/1ps
module tprc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Levels
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            stage1 <= '0;
            o_sync <= '0;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule : tprc_sync

// file: tprc_group_route.sv
// Channel select for one Type-C signal group, registered one-hot over four mux ports.
// Assumes the configuration inputs come from flip-flops on the same clock.
`timescale 1ns/1ps
module tprc_group_route (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Configuration
    input wire logic i_enable,
    input wire logic i_split,
    input wire logic [1:0] i_channel,
    input wire logic [1:0] i_field,
    // Switch control
    output logic [3:0] o_sel
);
    logic [1:0] port;

    // Route field counts only in split routing
    assign port = i_split ? i_field : i_channel;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sel <= 4'h0;
        end else begin
            o_sel <= i_enable ? (4'h1 << port) : 4'h0;
        end
    end
endmodule : tprc_group_route

// file: tprc_top.sv
// Configuration and status words of a four-way Type-C port selector.
// Assumes commands arrive already decoded from the control port, in the core clock domain;
// status pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
module tprc_top
    import tprc_pkg::*;
(
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RESETN,
    // Command port
    input wire logic I_CMD_VALID,
    input wire logic I_CMD_WRITE,
    input wire logic [3:0] I_CMD_OPT,
    input wire logic I_CMD_INST,
    input wire logic [1:0] I_CMD_CHAN,
    input wire logic [31:0] I_CMD_DATA,
    // Command response
    output logic O_RSP_VALID,
    output logic O_RSP_ERR,
    output logic [31:0] O_RSP_DATA,
    // Status pins
    input wire logic [1:0] I_COM_ORIENT,
    input wire logic [1:0] I_MUX_ORIENT,
    input wire logic [1:0] I_CARD_STATUS,
    input wire logic [2:0] I_ERR_FLAG,
    input wire logic I_CONN_UP,
    input wire logic [1:0] I_CC_PULSE,
    input wire logic [1:0] I_CC_LEVEL,
    // Group switch selects over mux ports 0 to 3, one-hot except VBUS in split routing
    output logic [3:0] O_SBU1_SEL,
    output logic [3:0] O_SBU2_SEL,
    output logic [3:0] O_CC1_SEL,
    output logic [3:0] O_CC2_SEL,
    output logic [3:0] O_HSA_SEL,
    output logic [3:0] O_HSB_SEL,
    output logic [3:0] O_SS1_SEL,
    output logic [3:0] O_SS2_SEL,
    output logic [3:0] O_VBUS_SEL,
    // Line controls
    output logic [3:0] O_FLIP,
    output logic O_KEEP_ALIVE,
    output logic O_AUTO_CONNECT,
    output logic [1:0] O_CC_INJECT,
    output logic [2:0] O_LANE_DIR,
    // Conditioner settings
    output logic [1:0] O_HS_RX_EQ,
    output logic [1:0] O_HS_TX_EQ,
    output logic [3:0] O_SS_TX_EQ,
    output logic [3:0] O_SS_RX_EQ_MUX,
    output logic [3:0] O_SS_RX_EQ_COM
);
    tprc_cmd_t cmd;
    tprc_pins_t pins_raw;
    tprc_pins_t pins;
    logic [31:0] req;
    logic [31:0] route;
    logic [2:0] lane_setting;
    logic [1:0] channel;
    logic split;
    logic [3:0] hs_rx;
    logic [3:0] hs_tx;
    logic [3:0] ss_tx;
    logic [3:0] ss_rx_mux;
    logic [3:0] ss_rx_com;
    logic [31:0] state_word;
    logic [NUM_GROUPS-1:0] grp_en;
    logic [3:0] grp_sel [NUM_GROUPS];
    logic wr;
    logic rd;
    logic bad;
    logic [31:0] next_rdata;

    assign cmd = '{I_CMD_VALID, I_CMD_WRITE, I_CMD_OPT, I_CMD_INST, I_CMD_CHAN, I_CMD_DATA};
    assign pins_raw = '{I_COM_ORIENT, I_MUX_ORIENT, I_CARD_STATUS, I_ERR_FLAG, I_CONN_UP,
                        I_CC_PULSE, I_CC_LEVEL};
    assign wr = cmd.valid && cmd.write && !bad;
    assign rd = cmd.valid && !cmd.write;

    tprc_sync #(
        .WIDTH($bits(tprc_pins_t))
    ) u_pin_sync (
        .i_clk(I_SYS_CLK),
        .i_resetn(I_RESETN),
        .i_async(pins_raw),
        .o_sync(pins)
    );

    // Writes outside the documented range are refused whole and leave the setting alone
    always_comb begin
        bad = 1'b0;
        if (cmd.write) begin
            unique case (cmd.opt)
                OPT_REQ_WORD, OPT_ROUTE_WORD: bad = 1'b0;
                OPT_STATE_WORD: bad = 1'b1;
                OPT_LANE_DIR: bad = cmd.data > LANE_DIR_MAX; // [R10]
                OPT_CHANNEL: bad = cmd.data > CHANNEL_MAX; // [R12]
                OPT_STYLE: bad = cmd.data > STYLE_MAX; // [R13]
                OPT_FLIP: bad = cmd.data > STYLE_MAX; // [R23]
                OPT_EQ_TX: bad = cmd.data > (cmd.inst ? SS_TX_MAX : HS_TX_MAX); // [R19]
                OPT_EQ_RX: begin
                    // Half-duplex high-speed path has one receiver, side 0 only
                    if (!cmd.inst) begin
                        bad = (cmd.chan != RX_SIDE_BOTH) || (cmd.data > HS_RX_MAX); // [R21]
                    end else begin
                        bad = (cmd.chan > RX_SIDE_COM) || (cmd.data > SS_RX_MAX); // [R20]
                    end
                end
                default: bad = 1'b1;
            endcase
        end
    end

    // Requested-connection word; cable flip drives all four flip requests together
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            req <= REQ_RESET;
        end else if (wr && cmd.opt == OPT_REQ_WORD) begin
            req <= cmd.data & REQ_WRITE_MASK; // [R1] [R5] [R22]
        end else if (wr && cmd.opt == OPT_FLIP) begin
            req[REQ_FLIP_LSB +: 4] <= {4{cmd.data[0]}}; // [R23]
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            route <= ROUTE_RESET;
        end else if (wr && cmd.opt == OPT_ROUTE_WORD) begin
            route <= cmd.data & ROUTE_WRITE_MASK; // [R16] [R17] [R22]
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            lane_setting <= LANE_DIR_RESET;
            channel <= CHANNEL_RESET;
            split <= 1'b0;
        end else if (wr) begin
            if (cmd.opt == OPT_LANE_DIR) begin
                lane_setting <= cmd.data[2:0]; // [R10]
            end
            if (cmd.opt == OPT_CHANNEL) begin
                channel <= cmd.data[1:0]; // [R12]
            end
            if (cmd.opt == OPT_STYLE) begin
                split <= cmd.data[0]; // [R13]
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            hs_rx <= EQ_RESET;
            hs_tx <= EQ_RESET;
            ss_tx <= EQ_RESET;
            ss_rx_mux <= EQ_RESET;
            ss_rx_com <= EQ_RESET;
        end else if (wr && cmd.opt == OPT_EQ_TX) begin
            if (cmd.inst) begin
                ss_tx <= cmd.data[3:0]; // [R19]
            end else begin
                hs_tx <= cmd.data[3:0]; // [R21]
            end
        end else if (wr && cmd.opt == OPT_EQ_RX) begin
            if (!cmd.inst) begin
                hs_rx <= cmd.data[3:0]; // [R21]
            end else begin
                if (cmd.chan != RX_SIDE_COM) begin
                    ss_rx_mux <= cmd.data[3:0]; // [R20]
                end
                if (cmd.chan != RX_SIDE_MUX) begin
                    ss_rx_com <= cmd.data[3:0]; // [R20]
                end
            end
        end
    end

    // Group order SBU1 SBU2 CC1 CC2 HSA HSB SS1 SS2
    assign grp_en = {req[REQ_SS2], req[REQ_SS1], req[REQ_HS_B], req[REQ_HS_A],
                     req[REQ_CC2], req[REQ_CC1], req[REQ_SBU], req[REQ_SBU]}; // [R2] [R3]

    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_route
        tprc_group_route u_route (
            .i_clk(I_SYS_CLK),
            .i_resetn(I_RESETN),
            .i_enable(grp_en[g]),
            .i_split(split), // [R14] [R15]
            .i_channel(channel),
            .i_field(route[ROUTE_LSB[g] +: 2]),
            .o_sel(grp_sel[g])
        );
    end

    assign O_SBU1_SEL = grp_sel[0];
    assign O_SBU2_SEL = grp_sel[1];
    assign O_CC1_SEL = grp_sel[2];
    assign O_CC2_SEL = grp_sel[3];
    assign O_HSA_SEL = grp_sel[4];
    assign O_HSB_SEL = grp_sel[5];
    assign O_SS1_SEL = grp_sel[6];
    assign O_SS2_SEL = grp_sel[7];

    // VBUS may feed several ports at once in split routing, so it is not one-hot there
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_VBUS_SEL <= 4'h0;
        end else if (!req[REQ_VBUS]) begin
            O_VBUS_SEL <= 4'h0;
        end else if (split) begin
            O_VBUS_SEL <= route[ROUTE_VBUS_LSB +: 4]; // [R18]
        end else begin
            O_VBUS_SEL <= 4'h1 << channel; // [R12] [R14]
        end
    end

    assign O_FLIP = req[REQ_FLIP_LSB +: 4]; // [R4]
    assign O_KEEP_ALIVE = req[REQ_KEEP_ALIVE]; // [R2]
    assign O_AUTO_CONNECT = req[REQ_AUTO_CONN]; // [R3]
    assign O_CC_INJECT = {req[REQ_INJ_CC2], req[REQ_INJ_CC1]}; // [R5]
    assign O_LANE_DIR = LANE_DIR_TABLE[lane_setting]; // [R11]
    assign O_HS_RX_EQ = hs_rx[1:0];
    assign O_HS_TX_EQ = hs_tx[1:0];
    assign O_SS_TX_EQ = ss_tx;
    assign O_SS_RX_EQ_MUX = ss_rx_mux;
    assign O_SS_RX_EQ_COM = ss_rx_com;

    // Line enables come from the switch selects, not the request, so they lag a write; flip and injection bits come from the request
    always_comb begin
        state_word = 32'h00000000; // [R22]
        state_word[0] = |O_VBUS_SEL; // [R6]
        state_word[1] = |O_HSA_SEL;
        state_word[2] = |O_HSB_SEL;
        state_word[3] = |O_SBU1_SEL;
        state_word[4] = |O_SS1_SEL;
        state_word[5] = |O_SS2_SEL;
        state_word[6] = |O_CC1_SEL;
        state_word[7] = |O_CC2_SEL;
        state_word[ST_COM_ORIENT +: 2] = pins.com_orient; // [R7]
        state_word[ST_MUX_ORIENT +: 2] = pins.mux_orient;
        state_word[ST_FLIP_LSB +: 3] = req[REQ_FLIP_LSB +: 3];
        state_word[ST_CARD +: 2] = pins.card; // [R8]
        state_word[ST_ERR +: 3] = pins.err;
        state_word[ST_CONN] = pins.conn;
        state_word[ST_INJ +: 2] = O_CC_INJECT; // [R9]
        state_word[ST_PULSE +: 2] = pins.pulse;
        state_word[ST_LEVEL +: 2] = pins.level;
    end

    always_comb begin
        next_rdata = 32'h00000000;
        unique case (cmd.opt)
            OPT_REQ_WORD: next_rdata = req;
            OPT_STATE_WORD: next_rdata = state_word;
            OPT_ROUTE_WORD: next_rdata = route;
            OPT_LANE_DIR: next_rdata = {29'h0, lane_setting};
            OPT_CHANNEL: next_rdata = {30'h0, channel};
            OPT_STYLE: next_rdata = {31'h0, split};
            OPT_FLIP: next_rdata = {31'h0, &req[REQ_FLIP_LSB +: 4]};
            OPT_EQ_TX: next_rdata = {28'h0, cmd.inst ? ss_tx : hs_tx};
            OPT_EQ_RX: next_rdata = {28'h0, (cmd.inst && cmd.chan == RX_SIDE_COM) ?
                                     ss_rx_com : (cmd.inst ? ss_rx_mux : hs_rx)};
            default: next_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_RSP_VALID <= 1'b0;
            O_RSP_ERR <= 1'b0;
            O_RSP_DATA <= 32'h00000000;
        end else begin
            O_RSP_VALID <= cmd.valid;
            O_RSP_ERR <= cmd.valid && (bad || (rd && cmd.opt > OPT_EQ_RX));
            O_RSP_DATA <= rd ? next_rdata : 32'h00000000;
        end
    end

    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RESETN);

    sequence s_write(logic [3:0] opt);
        I_CMD_VALID && I_CMD_WRITE && I_CMD_OPT == opt;
    endsequence

    sequence s_whole_steady;
        !split && $stable(split) && $stable(channel) && $stable(req);
    endsequence

    property p_req_mask;
        s_write(OPT_REQ_WORD) |=> req == ($past(I_CMD_DATA) & REQ_WRITE_MASK);
    endproperty
    a_req_mask: assert property (p_req_mask) else $error("request word not masked"); // [R22]

    property p_keep_alive;
        s_write(OPT_REQ_WORD) ##0 I_CMD_DATA[REQ_KEEP_ALIVE] |=> O_KEEP_ALIVE;
    endproperty
    a_keep_alive: assert property (p_keep_alive) else $error("keep-alive not set"); // [R2]

    property p_whole_cc1;
        s_whole_steady ##0 req[REQ_CC1] |=> O_CC1_SEL == (4'h1 << $past(channel));
    endproperty
    a_whole_cc1: assert property (p_whole_cc1) else $error("CC1 not on channel"); // [R14]

    property p_onehot;
        !$past(split) |-> $onehot0(O_SS1_SEL) && $onehot0(O_VBUS_SEL) && $onehot0(O_HSA_SEL);
    endproperty
    a_onehot: assert property (p_onehot) else $error("more than one mux port"); // [R12]

    property p_split_ss1;
        split && req[REQ_SS1] |=> O_SS1_SEL == (4'h1 << $past(route[17:16]));
    endproperty
    a_split_ss1: assert property (p_split_ss1) else $error("SS1 split route wrong"); // [R15]

    property p_split_vbus;
        split && req[REQ_VBUS] |=> O_VBUS_SEL == $past(route[23:20]);
    endproperty
    a_split_vbus: assert property (p_split_vbus) else $error("VBUS split route wrong"); // [R18]

    property p_lane_range;
        s_write(OPT_LANE_DIR) ##0 I_CMD_DATA > LANE_DIR_MAX |=> O_RSP_ERR && $stable(lane_setting);
    endproperty
    a_lane_range: assert property (p_lane_range) else $error("lane index accepted"); // [R10]

    property p_hs_rx_side;
        s_write(OPT_EQ_RX) ##0 !I_CMD_INST && I_CMD_CHAN != RX_SIDE_BOTH |=> O_RSP_ERR;
    endproperty
    a_hs_rx_side: assert property (p_hs_rx_side) else $error("HS rx side accepted"); // [R21]

    property p_rx_mux_only;
        s_write(OPT_EQ_RX) ##0 I_CMD_INST && I_CMD_CHAN == RX_SIDE_MUX ##0 !bad
            |=> $stable(ss_rx_com) && ss_rx_mux == $past(I_CMD_DATA[3:0]);
    endproperty
    a_rx_mux_only: assert property (p_rx_mux_only) else $error("mux side write wrong"); // [R20]

    property p_flip;
        s_write(OPT_FLIP) ##0 I_CMD_DATA == 32'h00000001
            |=> O_FLIP == 4'hF && state_word[ST_FLIP_LSB +: 3] == 3'h7;
    endproperty
    a_flip: assert property (p_flip) else $error("cable flip not applied"); // [R23]

    property p_state_err;
        $stable(I_ERR_FLAG) [*3] |-> state_word[22:20] == I_ERR_FLAG;
    endproperty
    a_state_err: assert property (p_state_err) else $error("error flag not reported"); // [R8]
endmodule : tprc_top

// file: tprc_host.sv
// Host-side model of the control port: issues one command at a time, returns the answer.
// Assumes every command starts just after a rising edge of the core clock.
`timescale 1ns/1ps
module tprc_host
    import tprc_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Command out, answer in
    output tprc_cmd_t o_cmd,
    input wire logic i_rsp_valid,
    input wire logic i_rsp_err,
    input wire logic [31:0] i_rsp_data
);
    initial begin
        o_cmd = '0;
    end
    // Held over exactly one edge; idle data is inverted so a stale word never looks valid
    task automatic xfer(input logic w, input logic [3:0] opt, input logic inst,
                        input logic [1:0] chan, input logic [31:0] data,
                        output logic ok, output logic err, output logic [31:0] rdata);
        o_cmd = '{valid: 1'b1, write: w, opt: opt, inst: inst, chan: chan, data: data};
        @(posedge i_clk);
        #1;
        ok = i_rsp_valid;
        err = i_rsp_err;
        rdata = i_rsp_data;
        o_cmd = '{valid: 1'b0, write: ~w, opt: ~opt, inst: ~inst, chan: ~chan, data: ~data};
        // One idle edge between commands, so the strobe is never rewritten in one time step
        @(posedge i_clk);
        #1;
    endtask : xfer
endmodule : tprc_host

// file: test_typec_port_route_config.sv
// Self-checking bench for the port route configuration block.
// Assumes the host model drives commands; status pins are driven here as levels.
`timescale 1ns/1ps
module test_typec_port_route_config
    import tprc_pkg::*;
();
    logic clk;
    logic rst_n;
    tprc_cmd_t cmd;
    tprc_pins_t pins;
    logic rsp_valid, rsp_err;
    logic [31:0] rsp_data;
    logic [3:0] sel [9];
    logic [3:0] flip, ss_tx, rx_mux, rx_com;
    logic keep, auto_c;
    logic [1:0] inj, hs_rx, hs_tx;
    logic [2:0] lane;
    int fail_count = 0;
    int n_compared = 0;

    always #2.5 clk = ~clk;

    tprc_host tprc_host_inst (.i_clk(clk), .o_cmd(cmd), .i_rsp_valid(rsp_valid),
        .i_rsp_err(rsp_err), .i_rsp_data(rsp_data));
    tprc_top tprc_top_inst (.I_SYS_CLK(clk), .I_RESETN(rst_n), .I_CMD_VALID(cmd.valid),
        .I_CMD_WRITE(cmd.write), .I_CMD_OPT(cmd.opt), .I_CMD_INST(cmd.inst),
        .I_CMD_CHAN(cmd.chan), .I_CMD_DATA(cmd.data), .O_RSP_VALID(rsp_valid),
        .O_RSP_ERR(rsp_err), .O_RSP_DATA(rsp_data), .I_COM_ORIENT(pins.com_orient),
        .I_MUX_ORIENT(pins.mux_orient), .I_CARD_STATUS(pins.card), .I_ERR_FLAG(pins.err),
        .I_CONN_UP(pins.conn), .I_CC_PULSE(pins.pulse), .I_CC_LEVEL(pins.level),
        .O_SBU1_SEL(sel[0]), .O_SBU2_SEL(sel[1]), .O_CC1_SEL(sel[2]), .O_CC2_SEL(sel[3]),
        .O_HSA_SEL(sel[4]), .O_HSB_SEL(sel[5]), .O_SS1_SEL(sel[6]), .O_SS2_SEL(sel[7]),
        .O_VBUS_SEL(sel[8]), .O_FLIP(flip), .O_KEEP_ALIVE(keep), .O_AUTO_CONNECT(auto_c),
        .O_CC_INJECT(inj), .O_LANE_DIR(lane), .O_HS_RX_EQ(hs_rx), .O_HS_TX_EQ(hs_tx),
        .O_SS_TX_EQ(ss_tx), .O_SS_RX_EQ_MUX(rx_mux), .O_SS_RX_EQ_COM(rx_com));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic op(input logic w, input logic [3:0] opt, input logic inst,
                      input logic [1:0] ch, input logic [31:0] d, input logic e_err,
                      input logic [31:0] e_data);
        logic ok, err;
        logic [31:0] rd;
        tprc_host_inst.xfer(w, opt, inst, ch, d, ok, err, rd);
        chk({30'h0, ok, err}, {30'h0, 1'b1, e_err});
        chk(rd, e_data);
    endtask : op

    task automatic settle;
        @(posedge clk);
        #1;
    endtask : settle

    // Expected one-hot select per group from a list of mux ports
    task automatic chk_sel(input logic [1:0] p [8]);
        for (int g = 0; g < 8; g++) begin
            chk(32'(sel[g]), 32'h1 << p[g]);
        end
    endtask : chk_sel

    task automatic complete_run;
        if (fail_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        pins = '0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        op(1'b0, OPT_REQ_WORD, 1'b0, 2'h0, 32'h0, 1'b0, 32'h0);
        op(1'b0, OPT_ROUTE_WORD, 1'b0, 2'h0, 32'h0, 1'b0, 32'h0);
        op(1'b1, OPT_REQ_WORD, 1'b0, 2'h0, 32'hFFFFFFFF, 1'b0, 32'h0);
        op(1'b0, OPT_REQ_WORD, 1'b0, 2'h0, 32'h0, 1'b0, 32'h001FF9F4);
        chk({24'h0, flip, keep, auto_c, inj}, {24'h0, 4'hF, 1'b1, 1'b1, 2'h3});
        for (int c = 0; c < 4; c++) begin
            op(1'b1, OPT_CHANNEL, 1'b0, 2'h0, 32'(c), 1'b0, 32'h0);
            settle();
            chk_sel('{default: 2'(c)});
            chk(32'(sel[8]), 32'h1 << c);
        end
        op(1'b1, OPT_CHANNEL, 1'b0, 2'h0, 32'h4, 1'b1, 32'h0);
        op(1'b0, OPT_CHANNEL, 1'b0, 2'h0, 32'h0, 1'b0, 32'h3);
        pins = '{com_orient: 2'h1, mux_orient: 2'h2, card: 2'h3, err: 3'h5, conn: 1'b1,
                 pulse: 2'h1, level: 2'h2};
        repeat (3) settle();
        op(1'b0, OPT_STATE_WORD, 1'b0, 2'h0, 32'h0, 1'b0, 32'h9CDDC9FF);
        op(1'b1, OPT_STATE_WORD, 1'b0, 2'h0, 32'h0, 1'b1, 32'h0);
        op(1'b1, OPT_ROUTE_WORD, 1'b0, 2'h0, 32'hFFFFFFFF, 1'b0, 32'h0);
        op(1'b0, OPT_ROUTE_WORD, 1'b0, 2'h0, 32'h0, 1'b0, 32'h00FFF33F);
        op(1'b1, OPT_ROUTE_WORD, 1'b0, 2'h0, 32'h00A39039, 1'b0, 32'h0);
        settle();
        chk_sel('{default: 2'h3});
        op(1'b1, OPT_STYLE, 1'b0, 2'h0, 32'h1, 1'b0, 32'h0);
        op(1'b1, OPT_STYLE, 1'b0, 2'h0, 32'h2, 1'b1, 32'h0);
        settle();
        chk_sel('{2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0});
        chk(32'(sel[8]), 32'hA);
        op(1'b1, OPT_REQ_WORD, 1'b0, 2'h0, 32'h001FB9F4, 1'b0, 32'h0);
        settle();
        chk({24'h0, sel[0], sel[1]}, 32'h0);
        op(1'b1, OPT_STYLE, 1'b0, 2'h0, 32'h0, 1'b0, 32'h0);
        settle();
        chk(32'(sel[4]), 32'h8);
        for (int i = 0; i < 8; i++) begin
            op(1'b1, OPT_LANE_DIR, 1'b0, 2'h0, 32'(i), 1'b0, 32'h0);
            chk(32'(lane), 32'(LANE_DIR_TABLE[i]));
        end
        op(1'b1, OPT_LANE_DIR, 1'b0, 2'h0, 32'h8, 1'b1, 32'h0);
        op(1'b1, OPT_FLIP, 1'b0, 2'h0, 32'h0, 1'b0, 32'h0);
        chk(32'(flip), 32'h0);
        op(1'b1, OPT_FLIP, 1'b0, 2'h0, 32'h1, 1'b0, 32'h0);
        chk(32'(flip), 32'hF);
        op(1'b0, OPT_FLIP, 1'b0, 2'h0, 32'h0, 1'b0, 32'h1);
        op(1'b1, OPT_EQ_RX, 1'b0, 2'h1, 32'h1, 1'b1, 32'h0);
        op(1'b1, OPT_EQ_RX, 1'b0, 2'h0, 32'h2, 1'b0, 32'h0);
        op(1'b1, OPT_EQ_TX, 1'b0, 2'h0, 32'h3, 1'b0, 32'h0);
        op(1'b1, OPT_EQ_TX, 1'b0, 2'h0, 32'h4, 1'b1, 32'h0);
        chk({28'h0, hs_rx, hs_tx}, 32'hB);
        op(1'b1, OPT_EQ_TX, 1'b1, 2'h0, 32'h8, 1'b0, 32'h0);
        op(1'b1, OPT_EQ_TX, 1'b1, 2'h0, 32'h9, 1'b1, 32'h0);
        chk(32'(ss_tx), 32'h8);
        op(1'b1, OPT_EQ_RX, 1'b1, 2'h0, 32'h9, 1'b0, 32'h0);
        chk({24'h0, rx_mux, rx_com}, 32'h99);
        op(1'b1, OPT_EQ_RX, 1'b1, 2'h1, 32'h5, 1'b0, 32'h0);
        chk({24'h0, rx_mux, rx_com}, 32'h59);
        op(1'b1, OPT_EQ_RX, 1'b1, 2'h2, 32'h3, 1'b0, 32'h0);
        op(1'b1, OPT_EQ_RX, 1'b1, 2'h3, 32'h1, 1'b1, 32'h0);
        chk({24'h0, rx_mux, rx_com}, 32'h53);
        complete_run();
    end
endmodule : test_typec_port_route_config
